// File: hdl/cesb_pkg.sv
// Constants and types shared by the control endpoint status block
package cesb_pkg;

   localparam int unsigned AXI_ADDR_W   = 20;
   localparam int unsigned AXI_DATA_W   = 32;
   localparam int unsigned REG_W        = 8;
   localparam int unsigned BULK_EPS     = 4;
   localparam int unsigned BULK_IDX_W   = 2;
   localparam int unsigned WLEN_W       = 16;
   localparam int unsigned IDX_W        = 16;
   localparam int unsigned ADDR_LSB     = 2;
   localparam int unsigned STRIDE_SHIFT = 2;

   // Register indices; the byte address on the bus is four times the index
   localparam logic [IDX_W-1:0] IDX_EP0_COUNT_LOW = 16'hE68B;
   localparam logic [IDX_W-1:0] IDX_BULK_A        = 16'hE691;
   localparam logic [IDX_W-1:0] IDX_BULK_B        = 16'hE695;
   localparam logic [IDX_W-1:0] IDX_BULK_C        = 16'hE699;
   localparam logic [IDX_W-1:0] IDX_BULK_D        = 16'hE69D;
   localparam logic [IDX_W-1:0] IDX_CTRL_STATUS   = 16'hE6A0;

   // Field positions and reset value of the control endpoint status register
   localparam int unsigned HOLD_BIT  = 7;
   localparam int unsigned BUSY_BIT  = 1;
   localparam int unsigned STALL_BIT = 0;
   localparam logic [REG_W-1:0] CTRL_STATUS_RST = 8'h80;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      PID_ACK   = 2'h0,
      PID_NAK   = 2'h1,
      PID_STALL = 2'h2,
      PID_DATA  = 2'h3
   } cesb_pid_t;

   typedef enum logic [3:0] {
      ST_IDLE     = 4'h1,
      ST_DATA_IN  = 4'h2,
      ST_DATA_OUT = 4'h4,
      ST_STATUS   = 4'h8
   } cesb_stage_t;

   typedef enum logic [1:0] {
      SEL_NONE      = 2'h0,
      SEL_EP0_COUNT = 2'h1,
      SEL_BULK      = 2'h2,
      SEL_STATUS    = 2'h3
   } cesb_sel_kind_t;

   typedef struct packed {
      cesb_sel_kind_t        kind;
      logic [BULK_IDX_W-1:0] bulk;
   } cesb_sel_t;

   // Token events from the serial engine, one-cycle pulses
   typedef struct packed {
      logic              setup;
      logic              in_tok;
      logic              out_tok;
      logic              dir_in;
      logic [WLEN_W-1:0] wlength;
   } cesb_tok_t;

   typedef struct packed {
      logic              valid;
      cesb_pid_t         pid;
      logic [WLEN_W-1:0] length;
   } cesb_hs_t;

endpackage

// File: hdl/cesb_cnt_mem.sv
// Small register-file memory holding the bulk endpoint low byte counts
`timescale 1ns/1ns
module cesb_cnt_mem #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 4,
   parameter int unsigned AW    = 2
) (
   input  wire logic             i_clk,
   input  wire logic             i_we,
   input  wire logic [AW-1:0]    i_waddr,
   input  wire logic [WIDTH-1:0] i_wdata,
   input  wire logic             i_re,
   input  wire logic [AW-1:0]    i_raddr,
   output logic      [WIDTH-1:0] o_rdata
);

   logic [WIDTH-1:0] mem_q [DEPTH];

   // No reset: the counts are undefined until software loads them
   always_ff @(posedge i_clk) begin
      if (i_we) begin
         mem_q[i_waddr] <= i_wdata;
      end
   end

   // Read data hold between reads so a stalled bus answer stays stable
   always_ff @(posedge i_clk) begin
      if (i_re) begin
         o_rdata <= mem_q[i_raddr];
      end
   end

endmodule // cesb_cnt_mem

// File: hdl/cesb_top.sv
// Control endpoint status, handshake reply and byte count registers
// Overview of operation
// - Each of the four bulk endpoints has a readable and writable eight-bit low byte count register.
// - The status stage is an empty packet opposite to the data stage, or an IN without data stage (the code also takes an OUT), answered ACK, NAK or STALL.
// - While the handshake hold bit 7 is set the status stage is not acknowledged.
// - Writing one to the handshake hold bit clears it, after which the status stage is acknowledged.
// - The busy flag at bit 1 is read only and is cleared when a SETUP token arrives.
// - Writing the control endpoint low byte count sets the busy flag.
// - The stall bit at bit 0 is read and write, set by writing one and cleared when a SETUP token arrives.
// - While stall is one every IN or OUT token is answered with STALL in data or handshake phase.
// - After reset the status register reads hold one, busy and stall zero.
// - A control IN reply carries the smaller of wLength and the loaded byte count.
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ns
module cesb_top (
   input  wire logic                             I_CORE_CLK,
   input  wire logic                             I_RST,
   input  wire logic [cesb_pkg::AXI_ADDR_W-1:0]  I_AWADDR,
   input  wire logic                             I_AWVALID,
   output logic                                  O_AWREADY,
   input  wire logic [cesb_pkg::AXI_DATA_W-1:0]  I_WDATA,
   input  wire logic [3:0]                       I_WSTRB,
   input  wire logic                             I_WVALID,
   output logic                                  O_WREADY,
   output logic [1:0]                            O_BRESP,
   output logic                                  O_BVALID,
   input  wire logic                             I_BREADY,
   input  wire logic [cesb_pkg::AXI_ADDR_W-1:0]  I_ARADDR,
   input  wire logic                             I_ARVALID,
   output logic                                  O_ARREADY,
   output logic [cesb_pkg::AXI_DATA_W-1:0]       O_RDATA,
   output logic [1:0]                            O_RRESP,
   output logic                                  O_RVALID,
   input  wire logic                             I_RREADY,
   input  wire cesb_pkg::cesb_tok_t              I_TOKEN,
   output cesb_pkg::cesb_hs_t                    O_HANDSHAKE
);
   import cesb_pkg::*;

   function automatic cesb_sel_t decode_addr(input logic [AXI_ADDR_W-1:0] addr);
      logic [IDX_W-1:0] idx;
      logic [IDX_W-1:0] off;
      cesb_sel_t        sel;
      idx      = addr[ADDR_LSB+IDX_W-1:ADDR_LSB];
      off      = idx - IDX_BULK_A;
      sel.kind = SEL_NONE;
      sel.bulk = off[STRIDE_SHIFT+BULK_IDX_W-1:STRIDE_SHIFT];
      if (addr[AXI_ADDR_W-1:ADDR_LSB+IDX_W] != '0 || addr[ADDR_LSB-1:0] != '0) begin
         sel.kind = SEL_NONE;
      end else if (idx == IDX_EP0_COUNT_LOW) begin
         sel.kind = SEL_EP0_COUNT;
      end else if (idx == IDX_CTRL_STATUS) begin
         sel.kind = SEL_STATUS;
      end else if (idx >= IDX_BULK_A && idx <= IDX_BULK_D && off[STRIDE_SHIFT-1:0] == '0) begin
         sel.kind = SEL_BULK;
      end
      return sel;
   endfunction

   function automatic logic [WLEN_W-1:0] min_len(input logic [WLEN_W-1:0] a, input logic [WLEN_W-1:0] b);
      return (a < b) ? a : b;
   endfunction

   // Bus write side
   logic                  aw_held_q;
   logic [AXI_ADDR_W-1:0] awaddr_q;
   logic                  w_held_q;
   logic [REG_W-1:0]      wdata_q;
   logic                  wlane_q;
   logic                  bvalid_q;
   logic [1:0]            bresp_q;
   // Bus read side
   logic                  rvalid_q;
   logic [1:0]            rresp_q;
   logic                  rd_bulk_q;
   logic [REG_W-1:0]      rd_local_q;
   logic [REG_W-1:0]      mem_rdata;
   // Endpoint state
   logic                  hold_q;
   logic                  hold_d;
   logic                  busy_q;
   logic                  busy_d;
   logic                  stall_q;
   logic                  stall_d;
   logic [REG_W-1:0]      count_q;
   logic [WLEN_W-1:0]     wlen_q;
   cesb_stage_t           stage_q;
   cesb_stage_t           stage_d;
   cesb_hs_t              hs_q;

   wire cesb_sel_t        wr_sel    = decode_addr(awaddr_q);
   wire cesb_sel_t        rd_sel    = decode_addr(I_ARADDR);
   wire                   aw_take   = I_AWVALID & O_AWREADY;
   wire                   w_take    = I_WVALID & O_WREADY;
   wire                   ar_take   = I_ARVALID & O_ARREADY;
   wire                   do_write  = aw_held_q & w_held_q & ~bvalid_q;
   wire                   wr_effect = do_write & wlane_q;
   wire                   cs_wr     = wr_effect & (wr_sel.kind == SEL_STATUS);
   wire                   cnt_wr    = wr_effect & (wr_sel.kind == SEL_EP0_COUNT);
   wire                   bulk_wr   = wr_effect & (wr_sel.kind == SEL_BULK);
   wire                   hold_clr  = cs_wr & wdata_q[HOLD_BIT];
   wire [REG_W-1:0]       cs_value  = {hold_q, {(HOLD_BIT-BUSY_BIT-1){1'b0}}, busy_q, stall_q};

   assign O_AWREADY = ~aw_held_q & ~bvalid_q;
   assign O_WREADY  = ~w_held_q & ~bvalid_q;
   assign O_BVALID  = bvalid_q;
   assign O_BRESP   = bresp_q;
   assign O_ARREADY = ~rvalid_q;
   assign O_RVALID  = rvalid_q;
   assign O_RRESP   = rresp_q;
   assign O_RDATA   = {{(AXI_DATA_W-REG_W){1'b0}}, rd_bulk_q ? mem_rdata : rd_local_q};
   assign O_HANDSHAKE = hs_q;

   // Address and data are parked separately so the master may offer them in either order
   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST) begin
         aw_held_q <= 1'b0;
         w_held_q  <= 1'b0;
         bvalid_q  <= 1'b0;
      end else begin
         aw_held_q <= aw_take | (aw_held_q & ~do_write);
         w_held_q  <= w_take | (w_held_q & ~do_write);
         bvalid_q  <= do_write | (bvalid_q & ~I_BREADY);
      end
   end

   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST) begin
         awaddr_q <= '0;
         wdata_q  <= '0;
         wlane_q  <= 1'b0;
         bresp_q  <= RESP_OKAY;
      end else begin
         if (aw_take) begin
            awaddr_q <= I_AWADDR;
         end
         if (w_take) begin
            wdata_q <= I_WDATA[REG_W-1:0];
            wlane_q <= I_WSTRB[0];
         end
         if (do_write) begin
            bresp_q <= (wr_sel.kind == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
         end
      end
   end

   // Status and count are captured at address time; bulk counts come from the memory register
   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST) begin
         rvalid_q   <= 1'b0;
         rresp_q    <= RESP_OKAY;
         rd_bulk_q  <= 1'b0;
         rd_local_q <= '0;
      end else begin
         rvalid_q <= ar_take | (rvalid_q & ~I_RREADY);
         if (ar_take) begin
            rresp_q    <= (rd_sel.kind == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
            rd_bulk_q  <= (rd_sel.kind == SEL_BULK);
            rd_local_q <= (rd_sel.kind == SEL_STATUS)    ? cs_value :
                          (rd_sel.kind == SEL_EP0_COUNT) ? count_q  : '0;
         end
      end
   end

   // Bulk counts come out of the memory's output register, so reads keep the same one-cycle answer
   cesb_cnt_mem #(
      .WIDTH (REG_W),
      .DEPTH (BULK_EPS),
      .AW    (BULK_IDX_W)
   ) u_bulk_counts (
      .i_clk   (I_CORE_CLK),
      .i_we    (bulk_wr),
      .i_waddr (wr_sel.bulk),
      .i_wdata (wdata_q),
      .i_re    (ar_take & (rd_sel.kind == SEL_BULK)),
      .i_raddr (rd_sel.bulk),
      .o_rdata (mem_rdata)
   );

   // Token classification against the control transfer stage
   wire tok_any     = I_TOKEN.in_tok | I_TOKEN.out_tok;
   wire in_status   = (stage_q == ST_STATUS) |
                      ((stage_q == ST_DATA_IN) & I_TOKEN.out_tok) |
                      ((stage_q == ST_DATA_OUT) & I_TOKEN.in_tok);
   wire in_data_in  = (stage_q == ST_DATA_IN) & I_TOKEN.in_tok;
   wire in_data_out = (stage_q == ST_DATA_OUT) & I_TOKEN.out_tok;
   wire status_ack  = tok_any & in_status & ~hold_q & ~stall_q;
   wire data_taken  = tok_any & ~stall_q & busy_q & (in_data_in | in_data_out);
   wire [WLEN_W-1:0] len_min = min_len(wlen_q, {{(WLEN_W-REG_W){1'b0}}, count_q});

   // Stall outranks everything, so a stalled endpoint never NAKs a token
   wire cesb_pid_t reply_pid = stall_q                 ? PID_STALL :
                               in_status               ? (hold_q ? PID_NAK : PID_ACK) :
                               in_data_in  & busy_q    ? PID_DATA  :
                               in_data_out & busy_q    ? PID_ACK   : PID_NAK;

   // A fresh SETUP re-arms the hold so firmware can inspect each request
   assign hold_d  = I_TOKEN.setup ? 1'b1 : (hold_clr ? 1'b0 : hold_q);
   assign busy_d  = cnt_wr ? 1'b1 : ((I_TOKEN.setup | data_taken) ? 1'b0 : busy_q);
   assign stall_d = cs_wr ? wdata_q[STALL_BIT] : (I_TOKEN.setup ? 1'b0 : stall_q);

   // A zero request length skips the data stage and goes straight to status
   always_comb begin
      stage_d = stage_q;
      if (I_TOKEN.setup) begin
         if (I_TOKEN.wlength == '0) begin
            stage_d = ST_STATUS;
         end else if (I_TOKEN.dir_in) begin
            stage_d = ST_DATA_IN;
         end else begin
            stage_d = ST_DATA_OUT;
         end
      end else if (status_ack) begin
         stage_d = ST_IDLE;
      end
   end

   // Hold comes out of reset set, so no status stage completes before firmware runs
   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST) begin
         hold_q  <= CTRL_STATUS_RST[HOLD_BIT];
         busy_q  <= CTRL_STATUS_RST[BUSY_BIT];
         stall_q <= CTRL_STATUS_RST[STALL_BIT];
         stage_q <= ST_IDLE;
      end else begin
         hold_q  <= hold_d;
         busy_q  <= busy_d;
         stall_q <= stall_d;
         stage_q <= stage_d;
      end
   end

   // Only the low count is kept; it limits the IN reply length
   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST) begin
         count_q <= '0;
         wlen_q  <= '0;
      end else begin
         if (cnt_wr) begin
            count_q <= wdata_q;
         end
         if (I_TOKEN.setup) begin
            wlen_q <= I_TOKEN.wlength;
         end
      end
   end

   // Registered reply trails its token by exactly one cycle
   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST) begin
         hs_q <= '0;
      end else begin
         hs_q.valid  <= tok_any & ~I_TOKEN.setup;
         hs_q.pid    <= reply_pid;
         hs_q.length <= (reply_pid == PID_DATA) ? len_min : '0;
      end
   end

   // Checks
   default clocking cb @(posedge I_CORE_CLK);
   endclocking
   default disable iff (I_RST);

   wire tok_ok = tok_any & ~I_TOKEN.setup;

   reset_state_a: assert property ($past(I_RST) |-> hold_q && !busy_q && !stall_q)
      else $error("status register not at reset value after reset");

   stall_reply_a: assert property (tok_ok && stall_q |=> hs_q.valid && hs_q.pid == PID_STALL)
      else $error("stalled endpoint did not answer STALL");

   hold_nak_a: assert property (tok_ok && in_status && hold_q && !stall_q |=> hs_q.pid == PID_NAK)
      else $error("status stage not held off while hold bit set");

   hold_release_a: assert property (tok_ok && in_status && !hold_q && !stall_q |=>
                                    hs_q.pid == PID_ACK && stage_q == ST_IDLE)
      else $error("status stage not acknowledged after hold release");

   hold_keep_a: assert property (cs_wr && !wdata_q[HOLD_BIT] && !I_TOKEN.setup |=> $stable(hold_q))
      else $error("writing zero changed the hold bit");

   setup_clear_a: assert property (I_TOKEN.setup && !cnt_wr && !cs_wr |=> !busy_q && !stall_q && hold_q)
      else $error("SETUP did not clear busy and stall");

   busy_set_a: assert property (cnt_wr |=> busy_q ##1 (busy_q || $past(I_TOKEN.setup) || $past(data_taken)))
      else $error("byte count write did not set busy");

   stall_set_a: assert property (cs_wr && wdata_q[STALL_BIT] |=> stall_q)
      else $error("writing one did not set stall");

   in_length_a: assert property (tok_ok && in_data_in && busy_q && !stall_q |=>
                                 hs_q.pid == PID_DATA && hs_q.length <= $past(wlen_q) &&
                                 hs_q.length <= {{(WLEN_W-REG_W){1'b0}}, $past(count_q)} &&
                                 (hs_q.length == $past(wlen_q) ||
                                  hs_q.length == {{(WLEN_W-REG_W){1'b0}}, $past(count_q)}))
      else $error("IN reply length is not the smaller count");

   write_resp_a: assert property (aw_take && w_take && !aw_held_q && !w_held_q |-> ##2 O_BVALID)
      else $error("write response not two cycles after address and data");

   read_resp_a: assert property (ar_take |=> O_RVALID)
      else $error("read data not one cycle after the address");

   unmapped_err_a: assert property (do_write && wr_sel.kind == SEL_NONE |=> O_BRESP == RESP_SLVERR)
      else $error("write to an unmapped address not refused");

   // A SETUP only loads state; the host never sees a reply to it
   setup_quiet_a: assert property (I_TOKEN.setup |=> !hs_q.valid)
      else $error("SETUP token produced a handshake");

   // Every IN or OUT token gets one reply, one cycle later
   token_reply_a: assert property (tok_ok |=> hs_q.valid)
      else $error("token not answered in the next cycle");

   stage_setup_a: assert property (I_TOKEN.setup && I_TOKEN.wlength == '0 |=> stage_q == ST_STATUS)
      else $error("request without data stage did not enter status");

   nak_idle_a: assert property (tok_ok && stage_q == ST_IDLE && !stall_q |=> hs_q.pid == PID_NAK)
      else $error("token outside a transfer not NAKed");

   // Guards against a stale stall leaking into a later transfer
   no_stall_a: assert property (tok_ok && !stall_q |=> hs_q.pid != PID_STALL)
      else $error("STALL sent while the stall bit was clear");

   hold_clear_a: assert property (hold_clr && !I_TOKEN.setup |=> !hold_q)
      else $error("writing one did not clear the hold bit");

   // Software cannot touch busy through the status register
   busy_ro_a: assert property (cs_wr && !cnt_wr && !I_TOKEN.setup && !data_taken |=> $stable(busy_q))
      else $error("status write changed the busy flag");

   cnt_load_a: assert property (cnt_wr |=> count_q == $past(wdata_q))
      else $error("byte count write not stored");

   // A taken OUT packet consumes the armed buffer
   out_ack_a: assert property (tok_ok && in_data_out && busy_q && !stall_q && !cnt_wr |=>
                               hs_q.pid == PID_ACK && !busy_q)
      else $error("armed OUT data stage not acknowledged");

   status_ack_c: cover property (tok_ok && in_status ##1 hs_q.pid == PID_ACK);
   stall_c:      cover property (tok_ok && stall_q && hold_q);
   data_in_c:    cover property (tok_ok && in_data_in && busy_q);
   bulk_rd_c:    cover property (ar_take && rd_sel.kind == SEL_BULK);
   hold_release_c: cover property (hold_clr ##[1:100] (tok_ok && in_status && !hold_q));

endmodule // cesb_top

// File: verif/cesb_host_model.sv
// Host side model issuing control endpoint tokens and capturing the reply
`timescale 1ns/1ns
module cesb_host_model (
   input  wire logic               i_clk,
   output cesb_pkg::cesb_tok_t     o_token,
   input  wire cesb_pkg::cesb_hs_t i_hs
);
   import cesb_pkg::*;

   initial o_token = '0;

   // Released fields toggle so a stale length or direction is never taken as live
   task automatic release_token();
      o_token <= '{1'b0, 1'b0, 1'b0, ~o_token.dir_in, ~o_token.wlength};
   endtask

   // A SETUP token only updates state, no reply is collected
   task automatic send_setup(input logic dir_in, input logic [WLEN_W-1:0] wlen);
      o_token <= '{1'b1, 1'b0, 1'b0, dir_in, wlen};
      @(posedge i_clk);
      release_token();
      @(posedge i_clk);
   endtask

   // The caller picks the direction, so a status stage goes opposite to the data stage
   task automatic send_token(input logic is_in, output logic v, output cesb_pid_t pid,
                             output logic [WLEN_W-1:0] len);
      o_token <= '{1'b0, is_in, ~is_in, o_token.dir_in, o_token.wlength};
      @(posedge i_clk);
      release_token();
      @(negedge i_clk);
      v = i_hs.valid;
      pid = i_hs.pid;
      len = i_hs.length;
      @(posedge i_clk);
   endtask
endmodule // cesb_host_model

// File: verif/tb.sv
// Self-checking bench for the control endpoint status block
`timescale 1ns/1ns
module tb;
   import cesb_pkg::*;
   localparam logic [AXI_ADDR_W-1:0] A_ST  = {2'h0, IDX_CTRL_STATUS, 2'h0};
   localparam logic [AXI_ADDR_W-1:0] A_EP0 = {2'h0, IDX_EP0_COUNT_LOW, 2'h0};
   localparam logic [AXI_ADDR_W-1:0] A_BAD = 20'h00010;
   localparam logic [AXI_ADDR_W-1:0] A_BULK [4] = '{{2'h0, IDX_BULK_A, 2'h0}, {2'h0, IDX_BULK_B, 2'h0},
                                                   {2'h0, IDX_BULK_C, 2'h0}, {2'h0, IDX_BULK_D, 2'h0}};
   localparam logic [7:0] BV [4] = '{8'h3C, 8'hC3, 8'h5A, 8'hA5};

   logic                  clk     = 1'b0;
   logic                  rst     = 1'b1;
   logic [AXI_ADDR_W-1:0] awaddr  = '0;
   logic [AXI_ADDR_W-1:0] araddr  = '0;
   logic [AXI_DATA_W-1:0] wdata   = '0;
   logic [3:0]            wstrb   = 4'h0;
   logic                  awvalid = 1'b0;
   logic                  wvalid  = 1'b0;
   logic                  bready  = 1'b0;
   logic                  arvalid = 1'b0;
   logic                  rready  = 1'b0;
   logic                  awready, wready, bvalid, arready, rvalid;
   logic [1:0]            bresp, rresp;
   logic [AXI_DATA_W-1:0] rdata;
   cesb_tok_t             tok;
   cesb_hs_t              hs;
   int                    fails = 0;
   int                    checks_done = 0;
   int                    cyc = 0;

   cesb_top i_cesb_top (.I_CORE_CLK(clk), .I_RST(rst), .I_AWADDR(awaddr), .I_AWVALID(awvalid),
      .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(wstrb), .I_WVALID(wvalid), .O_WREADY(wready),
      .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid),
      .O_ARREADY(arready), .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready),
      .I_TOKEN(tok), .O_HANDSHAKE(hs));

   cesb_host_model i_cesb_host_model (.i_clk(clk), .o_token(tok), .i_hs(hs));

   always #5 clk = ~clk;

   task automatic fail_msg(input string m);
      fails++;
      $display("CHECK FAILED t=%0t %s", $time, m);
   endtask

   task automatic chk_reg(input logic [AXI_DATA_W-1:0] got, input logic [AXI_DATA_W-1:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_msg($sformatf("register read %h expected %h", got, exp));
      end
   endtask

   task automatic chk_resp(input logic [2:0] got, input logic [2:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_msg($sformatf("bus response %h expected %h", got, exp));
      end
   endtask

   task automatic chk_hs(input logic [18:0] got, input logic [18:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_msg($sformatf("handshake %h expected %h", got, exp));
      end
   endtask

   // Both channels are offered together and each is dropped at its own handshake edge
   task automatic wr(input logic [AXI_ADDR_W-1:0] a, input logic [7:0] d, input logic [3:0] s,
                     input logic [1:0] er);
      logic aw_t, w_t, b_t;
      logic [1:0] rs;
      int n;
      n = 0;
      b_t = 1'b0;
      awaddr <= a;
      wdata <= {24'h000000, d};
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!b_t && n < 50) begin
         @(negedge clk);
         aw_t = awvalid && awready;
         w_t = wvalid && wready;
         b_t = bvalid;
         rs = bresp;
         @(posedge clk);
         if (aw_t) awvalid <= 1'b0;
         if (w_t) wvalid <= 1'b0;
         n++;
      end
      bready <= 1'b0;
      @(posedge clk);
      chk_resp({b_t, rs}, {1'b1, er});
   endtask

   task automatic rd(input logic [AXI_ADDR_W-1:0] a, input logic [7:0] e, input logic [1:0] er);
      logic ar_t, r_t;
      logic [1:0] rs;
      logic [AXI_DATA_W-1:0] d;
      int n;
      n = 0;
      r_t = 1'b0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!r_t && n < 50) begin
         @(negedge clk);
         ar_t = arvalid && arready;
         r_t = rvalid;
         rs = rresp;
         d = rdata;
         @(posedge clk);
         if (ar_t) arvalid <= 1'b0;
         n++;
      end
      rready <= 1'b0;
      @(posedge clk);
      chk_resp({r_t, rs}, {1'b1, er});
      chk_reg(d, {24'h000000, e});
   endtask

   task automatic usb(input logic is_in, input cesb_pid_t ep, input logic [WLEN_W-1:0] el);
      logic v;
      cesb_pid_t p;
      logic [WLEN_W-1:0] l;
      i_cesb_host_model.send_token(is_in, v, p, l);
      chk_hs({v, p, l}, {1'b1, ep, el});
   endtask

   task automatic t_bulk();
      for (int i = 0; i < 4; i++) begin
         wr(A_BULK[i], BV[i], 4'hF, RESP_OKAY);
      end
      for (int i = 0; i < 4; i++) begin
         rd(A_BULK[i], BV[i], RESP_OKAY);
      end
      wr(A_BULK[0], 8'hFF, 4'h0, RESP_OKAY);
      rd(A_BULK[0], BV[0], RESP_OKAY);
      wr(A_BAD, 8'h55, 4'hF, RESP_SLVERR);
      rd(A_BAD, 8'h00, RESP_SLVERR);
   endtask

   task automatic t_hold();
      i_cesb_host_model.send_setup(1'b0, 16'h0000);
      usb(1'b1, PID_NAK, 16'h0000);
      wr(A_ST, 8'h00, 4'hF, RESP_OKAY);
      rd(A_ST, 8'h80, RESP_OKAY);
      wr(A_ST, 8'h80, 4'hF, RESP_OKAY);
      rd(A_ST, 8'h00, RESP_OKAY);
      usb(1'b1, PID_ACK, 16'h0000);
      usb(1'b1, PID_NAK, 16'h0000);
   endtask

   // Reply length is the smaller of the request length and the loaded count
   task automatic t_data_in(input logic [WLEN_W-1:0] wl, input logic [7:0] cnt, input logic [WLEN_W-1:0] el);
      i_cesb_host_model.send_setup(1'b1, wl);
      usb(1'b1, PID_NAK, 16'h0000);
      wr(A_EP0, cnt, 4'hF, RESP_OKAY);
      rd(A_ST, 8'h82, RESP_OKAY);
      wr(A_ST, 8'h00, 4'hF, RESP_OKAY);
      rd(A_ST, 8'h82, RESP_OKAY);
      usb(1'b1, PID_DATA, el);
      rd(A_ST, 8'h80, RESP_OKAY);
      usb(1'b0, PID_NAK, 16'h0000);
      wr(A_ST, 8'h80, 4'hF, RESP_OKAY);
      usb(1'b0, PID_ACK, 16'h0000);
   endtask

   task automatic t_data_out();
      i_cesb_host_model.send_setup(1'b0, 16'h0004);
      usb(1'b0, PID_NAK, 16'h0000);
      wr(A_EP0, 8'h04, 4'hF, RESP_OKAY);
      usb(1'b0, PID_ACK, 16'h0000);
      rd(A_ST, 8'h80, RESP_OKAY);
      usb(1'b1, PID_NAK, 16'h0000);
      wr(A_ST, 8'h80, 4'hF, RESP_OKAY);
      usb(1'b1, PID_ACK, 16'h0000);
   endtask

   task automatic t_busy_setup();
      wr(A_EP0, 8'h01, 4'hF, RESP_OKAY);
      rd(A_ST, 8'h02, RESP_OKAY);
      i_cesb_host_model.send_setup(1'b0, 16'h0000);
      rd(A_ST, 8'h80, RESP_OKAY);
   endtask

   // Stall is set with the hold bit still up, as software must do for a real stall
   task automatic t_stall();
      wr(A_ST, 8'h01, 4'hF, RESP_OKAY);
      rd(A_ST, 8'h81, RESP_OKAY);
      usb(1'b1, PID_STALL, 16'h0000);
      usb(1'b0, PID_STALL, 16'h0000);
      i_cesb_host_model.send_setup(1'b1, 16'h0008);
      rd(A_ST, 8'h80, RESP_OKAY);
      usb(1'b1, PID_NAK, 16'h0000);
      wr(A_ST, 8'h01, 4'hF, RESP_OKAY);
      usb(1'b1, PID_STALL, 16'h0000);
      wr(A_ST, 8'h00, 4'hF, RESP_OKAY);
      rd(A_ST, 8'h80, RESP_OKAY);
   endtask

   task automatic end_of_test();
      if (fails == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // The whole run needs well under a thousand cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         fail_msg("run did not complete in time");
         end_of_test();
      end
   end

   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      rd(A_ST, 8'h80, RESP_OKAY);
      t_bulk();
      t_hold();
      t_data_in(16'h0005, 8'h09, 16'h0005);
      t_data_in(16'h0014, 8'h07, 16'h0007);
      t_data_in(16'h0008, 8'h08, 16'h0008);
      t_data_out();
      t_busy_setup();
      t_stall();
      end_of_test();
   end
endmodule // tb
